// ==== ccd_alu.sv ====
// result, destination and flag decisions for the file and accumulator ops
// purely combinational; the caller registers every effect
`timescale 1ns/10ps
module ccd_alu (
	input wire ccd_pkg::ccd_op_e op,
	input wire logic dest,
	input wire logic [7:0] fdata,
	output ccd_pkg::ccd_alu_s res
);
	import ccd_pkg::*;

	always_comb begin
		res = '0;
		case (op)
			OP_INVERT: begin
				res.result = ~fdata;
				res.wr_acc = ~dest;
				res.wr_file = dest;
				res.wr_z = 1'h1;
				res.z = (~fdata == 8'h00);
			end
			OP_ZERO_REG: begin
				res.wr_file = 1'h1;
				res.wr_z = 1'h1;
				res.z = 1'h1;
			end
			OP_CLEAR_ACC: begin
				res.wr_acc = 1'h1;
				res.wr_z = 1'h1;
				res.z = 1'h1;
			end
			OP_DEC: begin
				res.result = fdata - 8'h01;
				res.wr_acc = ~dest;
				res.wr_file = dest;
				res.wr_z = 1'h1;
				res.z = (fdata == 8'h01);
			end
			OP_DEC_SKIP: begin
				// flags untouched, only the skip decision
				res.result = fdata - 8'h01;
				res.wr_acc = ~dest;
				res.wr_file = dest;
				res.skip = (fdata == 8'h01);
			end
			default: begin
				res = '0;
			end
		endcase
	end
endmodule

// ==== ccd_core.sv ====
// execution unit for watchdog clear, call via accumulator, complement,
// clears and decrements, with an AXI4-Lite register slave
// assumes watchdog, sleep and stack logic elsewhere on the same aclk
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
module ccd_core (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic [6:0] program_counter_upper_latch,
	input wire logic watchdog_timeout,
	input wire logic sleep_entry,
	output logic wdt_count_clear,
	output logic wdt_prescale_clear,
	output ccd_pkg::ccd_push_s stack_push,
	output logic [7:0] accumulator,
	output logic zero_flag,
	output logic [14:0] program_counter,
	output logic watchdog_expired_flag,
	output logic sleep_entered_flag
);
	import ccd_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_NOP = 3'h4
	} ccd_state_e;

	ccd_state_e state;
	logic [13:0] ir;
	logic [BANK_W-1:0] bank;
	logic [MEM_AW-1:0] maddr;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic idle;
	logic in_exec;
	ccd_op_e op;
	ccd_alu_s alu;
	logic [7:0] fdata;
	logic [7:0] sw_rdata;
	logic [MEM_AW-1:0] rf_addr;
	logic rf_we;
	logic [31:0] next_word;
	logic [31:0] rd_val;
	logic [1:0] rd_resp;
	logic [1:0] wr_resp;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	assign idle = (state == ST_IDLE);
	assign in_exec = (state == ST_EXEC);
	assign op = ccd_decode(ir);
	assign rf_addr = {bank, ir[FADDR_W-1:0]};
	assign rf_we = in_exec & alu.wr_file;
	// both halves held and no response pending
	assign wr_fire = ~awready & ~wready & ~bvalid;

	ccd_regfile u_rf (
		.aclk(aclk),
		.core_addr(rf_addr),
		.core_rdata(fdata),
		.core_we(rf_we),
		.core_wdata(alu.result),
		.sw_addr(maddr),
		.sw_rdata(sw_rdata),
		.sw_we(wr_fire && idle && aw_addr == OFS_MDATA && w_strb[0]),
		.sw_wdata(w_data[7:0])
	);

	ccd_alu u_alu (
		.op(op),
		.dest(ir[DEST_BIT]),
		.fdata(fdata),
		.res(alu)
	);

	// write decode: software may only touch state while idle
	always_comb begin
		next_word = 32'h0000_0000;
		wr_resp = RESP_OKAY;
		case (aw_addr)
			OFS_INSTR: next_word = wmerge({18'h00000, ir}, w_data, w_strb);
			OFS_ACC: next_word = wmerge({24'h000000, accumulator}, w_data, w_strb);
			OFS_PC: next_word = wmerge({17'h00000, program_counter}, w_data, w_strb);
			OFS_BANK: next_word = wmerge({30'h00000000, bank}, w_data, w_strb);
			OFS_MADDR: next_word = wmerge({23'h000000, maddr}, w_data, w_strb);
			OFS_MDATA: next_word = w_data;
			OFS_STAT: next_word = 32'h0000_0000;
			default: wr_resp = RESP_DECERR;
		endcase
		if (wr_resp == RESP_OKAY && !idle && aw_addr != OFS_STAT) begin
			wr_resp = RESP_SLVERR;
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_resp = RESP_OKAY;
		case (araddr)
			OFS_INSTR: rd_val[13:0] = ir;
			OFS_ACC: rd_val[7:0] = accumulator;
			OFS_PC: rd_val[14:0] = program_counter;
			OFS_BANK: rd_val[BANK_W-1:0] = bank;
			OFS_MADDR: rd_val[MEM_AW-1:0] = maddr;
			OFS_MDATA: rd_val[7:0] = sw_rdata;
			OFS_STAT: begin
				rd_val[ST_Z_BIT] = zero_flag;
				rd_val[ST_EXP_BIT] = watchdog_expired_flag;
				rd_val[ST_SLP_BIT] = sleep_entered_flag;
				rd_val[ST_BUSY_BIT] = ~idle;
			end
			default: rd_resp = RESP_DECERR;
		endcase
	end

	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'h1;
			wready <= 1'h1;
			bvalid <= 1'h0;
			bresp <= RESP_OKAY;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'h0;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'h0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_fire) begin
				bvalid <= 1'h1;
				bresp <= wr_resp;
			end
			if (bvalid && bready) begin
				bvalid <= 1'h0;
				awready <= 1'h1;
				wready <= 1'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'h1;
			rvalid <= 1'h0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'h0;
			rvalid <= 1'h1;
			rdata <= rd_val;
			rresp <= rd_resp;
		end else if (rvalid && rready) begin
			rvalid <= 1'h0;
			arready <= 1'h1;
		end
	end

	// software-owned configuration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir <= IR_RST;
			bank <= BANK_RST;
			maddr <= MADDR_RST;
		end else if (wr_fire && idle) begin
			if (aw_addr == OFS_INSTR) begin
				ir <= next_word[13:0];
			end
			if (aw_addr == OFS_BANK) begin
				bank <= next_word[BANK_W-1:0];
			end
			if (aw_addr == OFS_MADDR) begin
				maddr <= next_word[MEM_AW-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (wr_fire && aw_addr == OFS_INSTR) begin
						state <= ST_EXEC;
					end
				end
				ST_EXEC: state <= (op == OP_CALL_ACC || alu.skip) ? ST_NOP : ST_IDLE;
				ST_NOP: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			accumulator <= ACC_RST;
		end else if (in_exec && alu.wr_acc) begin
			accumulator <= alu.result;
		end else if (wr_fire && idle && aw_addr == OFS_ACC) begin
			accumulator <= next_word[7:0];
		end
	end

	// zero only where the op owns it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			zero_flag <= Z_RST;
		end else if (in_exec && alu.wr_z) begin
			zero_flag <= alu.z;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_counter <= PC_RST;
		end else if (in_exec) begin
			program_counter <= (op == OP_CALL_ACC) ? {program_counter_upper_latch, accumulator}
				: program_counter + 15'h0001;
		end else if (state == ST_NOP) begin
			// the call's flush slot does not advance the new target
			if (op != OP_CALL_ACC) begin
				program_counter <= program_counter + 15'h0001;
			end
		end else if (wr_fire && idle && aw_addr == OFS_PC) begin
			program_counter <= next_word[14:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stack_push <= '0;
		end else begin
			stack_push.valid <= in_exec && op == OP_CALL_ACC;
			stack_push.addr <= program_counter + 15'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_count_clear <= 1'h0;
			wdt_prescale_clear <= 1'h0;
		end else begin
			wdt_count_clear <= in_exec && op == OP_WDT_CLEAR;
			wdt_prescale_clear <= in_exec && op == OP_WDT_CLEAR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_expired_flag <= EXP_RST;
			sleep_entered_flag <= SLP_RST;
		end else if (in_exec && op == OP_WDT_CLEAR) begin
			watchdog_expired_flag <= 1'h1;
			sleep_entered_flag <= 1'h1;
		end else begin
			if (watchdog_timeout) begin
				watchdog_expired_flag <= 1'h0;
			end
			if (sleep_entry) begin
				sleep_entered_flag <= 1'h0;
			end
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	wdt_clear_a: assert property (
		in_exec && op == OP_WDT_CLEAR |=> wdt_count_clear && wdt_prescale_clear ##1 !wdt_count_clear)
		else $error("watchdog clear strobes wrong");
	status_set_a: assert property (
		in_exec && op == OP_WDT_CLEAR |=> watchdog_expired_flag && sleep_entered_flag)
		else $error("watchdog status bits not set");
	call_push_a: assert property (
		in_exec && op == OP_CALL_ACC |=> stack_push.valid && stack_push.addr == $past(program_counter) + 15'h0001)
		else $error("return address push wrong");
	call_target_a: assert property (
		in_exec && op == OP_CALL_ACC |=> program_counter == {$past(program_counter_upper_latch), $past(accumulator)}
		&& $stable(zero_flag) ##1 $stable(program_counter))
		else $error("call target wrong");
	call_length_a: assert property (
		in_exec && op == OP_CALL_ACC |=> state == ST_NOP ##1 state == ST_IDLE)
		else $error("call not two cycles");
	dest_select_a: assert property (
		in_exec && (op == OP_INVERT || op == OP_DEC || op == OP_DEC_SKIP) |->
		(rf_we == ir[DEST_BIT]) ##1 (ir[DEST_BIT] || accumulator == $past(alu.result)))
		else $error("destination select wrong");
	invert_a: assert property (
		in_exec && op == OP_INVERT |-> alu.result == ~fdata ##1 zero_flag == ($past(fdata) == 8'hff))
		else $error("complement result wrong");
	clear_reg_a: assert property (
		in_exec && op == OP_ZERO_REG |-> rf_we && alu.result == 8'h00 ##1 zero_flag)
		else $error("register clear wrong");
	clear_acc_a: assert property (
		in_exec && op == OP_CLEAR_ACC |=> accumulator == 8'h00 && zero_flag && !stack_push.valid)
		else $error("accumulator clear wrong");
	decrement_a: assert property (
		in_exec && op == OP_DEC |=> zero_flag == ($past(fdata) == 8'h01)
		&& ($past(ir[DEST_BIT]) || accumulator == $past(fdata) - 8'h01))
		else $error("decrement wrong");
	skip_zero_a: assert property (
		in_exec && op == OP_DEC_SKIP |=> $stable(zero_flag) && (state == ST_NOP) == ($past(fdata) == 8'h01))
		else $error("decrement skip wrong");
	bank_addr_a: assert property (
		rf_we |-> rf_addr[MEM_AW-1:FADDR_W] == bank && rf_addr[FADDR_W-1:0] == ir[FADDR_W-1:0])
		else $error("register address outside bank");

	call_seen_c: cover property (in_exec && op == OP_CALL_ACC ##2 idle);
	skip_seen_c: cover property (in_exec && op == OP_DEC_SKIP && alu.skip);
	wdt_seen_c: cover property (in_exec && op == OP_WDT_CLEAR && watchdog_timeout);
	busy_write_c: cover property (wr_fire && !idle);
endmodule

// ==== ccd_pkg.sv ====
// constants, types and decode helper for the clear/call/decrement execution block
// assumes a single aclk domain and an AXI4-Lite master with 32-bit data
package ccd_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_INSTR = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_PC = 8'h0c;
	localparam logic [7:0] OFS_BANK = 8'h10;
	localparam logic [7:0] OFS_MADDR = 8'h14;
	localparam logic [7:0] OFS_MDATA = 8'h18;
	// status register bit positions
	localparam int ST_Z_BIT = 0;
	localparam int ST_EXP_BIT = 1;
	localparam int ST_SLP_BIT = 2;
	localparam int ST_BUSY_BIT = 3;
	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [14:0] PC_RST = 15'h0000;
	localparam logic [13:0] IR_RST = 14'h0000;
	localparam logic [1:0] BANK_RST = 2'h0;
	localparam logic [8:0] MADDR_RST = 9'h000;
	localparam logic Z_RST = 1'h0;
	localparam logic EXP_RST = 1'h1;
	localparam logic SLP_RST = 1'h1;
	// instruction word layout
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int DEST_BIT = 7;
	localparam int FADDR_W = 7;
	localparam int BANK_W = 2;
	localparam int MEM_AW = FADDR_W + BANK_W;
	localparam int MEM_DEPTH = 512;
	// opcode field values
	localparam logic [5:0] OPC_WDT_CLEAR = 6'h01;
	localparam logic [5:0] OPC_CALL_ACC = 6'h02;
	localparam logic [5:0] OPC_INVERT = 6'h03;
	localparam logic [5:0] OPC_ZERO_REG = 6'h04;
	localparam logic [5:0] OPC_CLEAR_ACC = 6'h05;
	localparam logic [5:0] OPC_DEC = 6'h06;
	localparam logic [5:0] OPC_DEC_SKIP = 6'h07;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		OP_NONE, OP_WDT_CLEAR, OP_CALL_ACC, OP_INVERT, OP_ZERO_REG, OP_CLEAR_ACC, OP_DEC, OP_DEC_SKIP
	} ccd_op_e;

	typedef struct packed {
		logic valid;
		logic [14:0] addr;
	} ccd_push_s;

	typedef struct packed {
		logic [7:0] result;
		logic wr_acc;
		logic wr_file;
		logic wr_z;
		logic z;
		logic skip;
	} ccd_alu_s;

	function automatic ccd_op_e ccd_decode(input logic [13:0] ins);
		case (ins[OPC_HI:OPC_LO])
			OPC_WDT_CLEAR: ccd_decode = OP_WDT_CLEAR;
			OPC_CALL_ACC: ccd_decode = OP_CALL_ACC;
			OPC_INVERT: ccd_decode = OP_INVERT;
			OPC_ZERO_REG: ccd_decode = OP_ZERO_REG;
			OPC_CLEAR_ACC: ccd_decode = OP_CLEAR_ACC;
			OPC_DEC: ccd_decode = OP_DEC;
			OPC_DEC_SKIP: ccd_decode = OP_DEC_SKIP;
			default: ccd_decode = OP_NONE;
		endcase
	endfunction
endpackage

// ==== ccd_regfile.sv ====
// banked data register file, one core port and one software port
// assumes both ports never write the same cycle; core wins if they do
`timescale 1ns/10ps
module ccd_regfile (
	input wire logic aclk,
	input wire logic [ccd_pkg::MEM_AW-1:0] core_addr,
	output logic [7:0] core_rdata,
	input wire logic core_we,
	input wire logic [7:0] core_wdata,
	input wire logic [ccd_pkg::MEM_AW-1:0] sw_addr,
	output logic [7:0] sw_rdata,
	input wire logic sw_we,
	input wire logic [7:0] sw_wdata
);
	import ccd_pkg::*;

	// contents are undefined after reset, as in a real data ram
	logic [7:0] mem [MEM_DEPTH];

	assign core_rdata = mem[core_addr];
	assign sw_rdata = mem[sw_addr];

	always_ff @(posedge aclk) begin
		if (core_we) begin
			mem[core_addr] <= core_wdata;
		end else if (sw_we) begin
			mem[sw_addr] <= sw_wdata;
		end
	end
endmodule

// ==== tb.sv ====
// self-checking bench for the clear/call/decrement execution block
// assumes the block answers AXI4-Lite in a few cycles and settles two edges after an op
`timescale 1ns/10ps
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %0t %s", $time, m); end end
module tb;
	import ccd_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rr;
	logic [6:0] latch;
	logic wdt_trip, slp_in, wcc, wpc, zf, expf, slpf;
	ccd_push_s push;
	logic [7:0] acc;
	logic [14:0] pc, exp_pc, push_addr;
	int err_count, compares, push_count, wcc_count, wboth_count;
	ccd_core ccd_core_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.program_counter_upper_latch(latch), .watchdog_timeout(wdt_trip), .sleep_entry(slp_in),
		.wdt_count_clear(wcc), .wdt_prescale_clear(wpc), .stack_push(push), .accumulator(acc),
		.zero_flag(zf), .program_counter(pc), .watchdog_expired_flag(expf),
		.sleep_entered_flag(slpf));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// side-effect monitors; counts only move on a real pulse
	always @(posedge aclk) begin
		if (push.valid === 1'b1) begin
			push_count <= push_count + 1;
			push_addr <= push.addr;
		end
		if (wcc === 1'b1)
			wcc_count <= wcc_count + 1;
		if (wcc === 1'b1 && wpc === 1'b1)
			wboth_count <= wboth_count + 1;
	end
	task automatic results();
		$display("compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic timed_out();
		err_count++;
		$display("MISMATCH %0t bus wait ran out", $time);
		results();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit aw_up;
		bit w_up;
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		aw_up = 1;
		w_up = 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (aw_up && awready === 1'b1) begin
				awvalid <= 1'b0;
				aw_up = 0;
			end
			if (w_up && wready === 1'b1) begin
				wvalid <= 1'b0;
				w_up = 0;
			end
			if (bvalid === 1'b1) begin
				r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		timed_out();
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		bit ar_up;
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		ar_up = 1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (ar_up && arready === 1'b1) begin
				arvalid <= 1'b0;
				ar_up = 0;
			end
			if (rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				return;
			end
		end
		timed_out();
	endtask
	task automatic set_ram(input logic [8:0] a, input logic [7:0] v);
		wr(OFS_MADDR, {23'h0, a}, rr);
		wr(OFS_MDATA, {24'h0, v}, rr);
	endtask
	task automatic get_ram(input logic [8:0] a, output logic [7:0] v);
		wr(OFS_MADDR, {23'h0, a}, rr);
		rd_reg(OFS_MDATA, rd, rr);
		v = rd[7:0];
	endtask
	// effects land one edge after the write answer, idle on that same edge, or one edge later after a call or a taken skip
	task automatic exec(input logic [5:0] opc, input logic dest, input logic [6:0] f, input int step);
		wr(OFS_INSTR, {18'h0, opc, dest, f}, rr);
		repeat (3) @(posedge aclk);
		exp_pc = exp_pc + 15'(step);
	endtask
	initial begin
		logic [7:0] v;
		int p0;
		int w0;
		int b0;
		{awvalid, wvalid, bready, arvalid, rready, wdt_trip, slp_in} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		latch = 7'h00;
		err_count = 0;
		compares = 0;
		push_count = 0;
		wcc_count = 0;
		wboth_count = 0;
		exp_pc = 15'h0000;
		aresetn = 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_reg(OFS_STAT, rd, rr);
		`CHK(rd, 32'h0000_0006, "status after reset")
		rd_reg(8'hfc, rd, rr);
		`CHK(rr, RESP_DECERR, "unmapped read response")
		`CHK(rd, 32'h0, "unmapped read data")
		// same offset in two banks tells the bank field apart
		wr(OFS_BANK, 32'h1, rr);
		set_ram(9'h085, 8'h5a);
		set_ram(9'h005, 8'h11);
		exec(OPC_INVERT, 1'b1, 7'h05, 1);
		get_ram(9'h085, v);
		`CHK(v, 8'ha5, "invert to register")
		`CHK(zf, 1'b0, "invert zero clear")
		get_ram(9'h005, v);
		`CHK(v, 8'h11, "other bank untouched")
		set_ram(9'h085, 8'hff);
		exec(OPC_INVERT, 1'b0, 7'h05, 1);
		`CHK(acc, 8'h00, "invert to accumulator")
		`CHK(zf, 1'b1, "invert zero set")
		get_ram(9'h085, v);
		`CHK(v, 8'hff, "register kept on dest 0")
		exec(OPC_DEC, 1'b1, 7'h05, 1);
		get_ram(9'h085, v);
		`CHK(v, 8'hfe, "decrement to register")
		`CHK(zf, 1'b0, "decrement nonzero")
		`CHK(acc, 8'h00, "accumulator kept on dest 1")
		set_ram(9'h085, 8'h01);
		exec(OPC_DEC, 1'b0, 7'h05, 1);
		`CHK(acc, 8'h00, "decrement to zero")
		`CHK(zf, 1'b1, "decrement zero set")
		set_ram(9'h085, 8'h33);
		exec(OPC_ZERO_REG, 1'b1, 7'h05, 1);
		get_ram(9'h085, v);
		`CHK(v, 8'h00, "register cleared")
		`CHK(zf, 1'b1, "register clear zero")
		// wrap below zero leaves the zero flag low ahead of the accumulator clear
		exec(OPC_DEC, 1'b0, 7'h05, 1);
		`CHK(acc, 8'hff, "decrement wraps")
		`CHK(zf, 1'b0, "wrap zero clear")
		exec(OPC_CLEAR_ACC, 1'b0, 7'h00, 1);
		`CHK(acc, 8'h00, "accumulator cleared")
		`CHK(zf, 1'b1, "accumulator clear zero")
		`CHK(pc, exp_pc, "single step counter")
		set_ram(9'h085, 8'h02);
		exec(OPC_DEC_SKIP, 1'b1, 7'h05, 1);
		get_ram(9'h085, v);
		`CHK(v, 8'h01, "skip decrement to register")
		`CHK(pc, exp_pc, "no skip on nonzero")
		// nonzero result would clear zero if the op wrongly owned it
		`CHK(zf, 1'b1, "skip keeps zero on nonzero")
		exec(OPC_DEC_SKIP, 1'b0, 7'h05, 2);
		`CHK(acc, 8'h00, "skip decrement to accumulator")
		`CHK(pc, exp_pc, "next slot discarded")
		`CHK(zf, 1'b1, "skip leaves zero alone")
		wr(OFS_ACC, 32'h0000_003c, rr);
		`CHK(rr, RESP_OKAY, "accumulator write answer")
		latch <= 7'h55;
		p0 = push_count;
		exec(OPC_CALL_ACC, 1'b0, 7'h00, 0);
		`CHK(push_count - p0, 1, "one push")
		`CHK(push_addr, exp_pc + 15'h1, "return address")
		`CHK(pc, {7'h55, 8'h3c}, "call target")
		`CHK(zf, 1'b1, "call keeps flags")
		exp_pc = {7'h55, 8'h3c};
		wdt_trip <= 1'b1;
		slp_in <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK({expf, slpf}, 2'b00, "status flags dropped")
		w0 = wcc_count;
		b0 = wboth_count;
		// clear inputs stay high through the op, so the set has to win
		wr(OFS_INSTR, {18'h0, OPC_WDT_CLEAR, 8'h00}, rr);
		wdt_trip <= 1'b0;
		slp_in <= 1'b0;
		repeat (3) @(posedge aclk);
		exp_pc = exp_pc + 15'h0001;
		`CHK(wcc_count - w0, 1, "one count clear pulse")
		`CHK(wboth_count - b0, 1, "prescaler cleared alongside")
		`CHK({expf, slpf}, 2'b11, "flags set by watchdog clear")
		`CHK(pc, exp_pc, "counter after watchdog clear")
		results();
	end
endmodule
